// *** hdl/sns_defines.svh ***
// register offsets, field positions, reset values and opcode fields of the subtract/swap datapath
`ifndef SNS_DEFINES_SVH
`define SNS_DEFINES_SVH

`define SNS_OFF_ACC     12'h000
`define SNS_OFF_STATUS  12'h004
`define SNS_OFF_CTRL    12'h008
`define SNS_OFF_RESULT  12'h00C

`define SNS_BIT_C       0
`define SNS_BIT_DC      1
`define SNS_BIT_Z       2
`define SNS_BIT_EN      0
`define SNS_BIT_DEST    7

`define SNS_RST_ACC     8'h00
`define SNS_RST_FLAGS   3'h0
`define SNS_RST_EN      1'b1
`define SNS_RST_RESULT  8'h00

`define SNS_TOP_LIT     2'h3
`define SNS_FLD_LIT     3'h6
`define SNS_TOP_REG     2'h0
`define SNS_FLD_SUB     4'h2
`define SNS_FLD_SWAP    4'hE

`endif

// *** hdl/sns_pkg.sv ***
// types shared by the subtract/swap datapath
package sns_pkg;

   typedef struct packed {
      logic z;
      logic nibble_borrow_bit;
      logic c;
   } sns_flags_type;

   typedef struct packed {
      logic       we;
      logic [6:0] addr;
      logic [7:0] data;
   } sns_fwr_type;

   typedef enum logic [1:0] {
      SNS_OP_NONE,
      SNS_OP_LIT_MINUS_ACC,
      SNS_OP_REG_MINUS_ACC,
      SNS_OP_NIBBLE_EXCHANGE
   } sns_op_type;

endpackage : sns_pkg

// *** hdl/sns_ops.sv ***
// subtract and nibble exchange execution datapath with apb register access
`timescale 1ns/1ps
`include "sns_defines.svh"

module sns_ops #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic                  I_CORE_CLK,
   input  wire logic                  I_RST,
   // core instruction side
   input  wire logic                  I_EXEC,
   input  wire logic [13:0]           I_INSTR,
   input  wire logic [7:0]            I_FILE_RDATA,
   output sns_pkg::sns_fwr_type       O_FILE_WR,
   output logic [7:0]                 O_ACC,
   output sns_pkg::sns_flags_type     O_FLAGS,
   output logic                       O_DONE,
   output logic                       O_UNKNOWN,
   // apb slave
   input  wire logic                  I_PSEL,
   input  wire logic                  I_PENABLE,
   input  wire logic                  I_PWRITE,
   input  wire logic [ADDR_W-1:0]     I_PADDR,
   input  wire logic [31:0]           I_PWDATA,
   output logic                       O_PREADY,
   output logic [31:0]                O_PRDATA,
   output logic                       O_PSLVERR
);

   sns_pkg::sns_op_type   op;
   logic                  enable;
   logic                  take;
   logic                  is_sub;
   logic                  to_file;
   logic [7:0]            operand;
   logic [8:0]            diff9;
   logic [4:0]            nib5;
   logic [7:0]            result;
   logic [7:0]            last_result;
   logic                  apb_wr;
   logic                  wr_acc;
   logic                  wr_status;
   logic                  wr_ctrl;
   logic                  bad_addr;

   // opcode decode
   always_comb begin
      op = sns_pkg::SNS_OP_NONE;
      if (I_INSTR[13:12] == `SNS_TOP_LIT && I_INSTR[11:9] == `SNS_FLD_LIT) begin
         op = sns_pkg::SNS_OP_LIT_MINUS_ACC;
      end else if (I_INSTR[13:12] == `SNS_TOP_REG) begin
         case (I_INSTR[11:8])
            `SNS_FLD_SUB:  op = sns_pkg::SNS_OP_REG_MINUS_ACC;
            `SNS_FLD_SWAP: op = sns_pkg::SNS_OP_NIBBLE_EXCHANGE;
            default:       op = sns_pkg::SNS_OP_NONE;
         endcase
      end
   end

   assign take    = I_EXEC & enable;
   assign is_sub  = (op == sns_pkg::SNS_OP_LIT_MINUS_ACC) || (op == sns_pkg::SNS_OP_REG_MINUS_ACC);
   assign to_file = (op != sns_pkg::SNS_OP_LIT_MINUS_ACC) & I_INSTR[`SNS_BIT_DEST];
   assign operand = (op == sns_pkg::SNS_OP_LIT_MINUS_ACC) ? I_INSTR[7:0] : I_FILE_RDATA;

   assign diff9 = {1'b0, operand} + {1'b0, ~O_ACC} + 9'h001;
   assign nib5  = {1'b0, operand[3:0]} + {1'b0, ~O_ACC[3:0]} + 5'h01;

   always_comb begin
      if (is_sub) begin
         result = diff9[7:0];
      end else begin
         result = {operand[3:0], operand[7:4]};
      end
   end

   // apb write decode
   assign apb_wr    = I_PSEL & I_PENABLE & I_PWRITE;
   assign wr_acc    = apb_wr && (I_PADDR == ADDR_W'(`SNS_OFF_ACC));
   assign wr_status = apb_wr && (I_PADDR == ADDR_W'(`SNS_OFF_STATUS));
   assign wr_ctrl   = apb_wr && (I_PADDR == ADDR_W'(`SNS_OFF_CTRL));

   // accumulator: an executing instruction wins over a bus write
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_ACC <= `SNS_RST_ACC;
      end else if (take && op != sns_pkg::SNS_OP_NONE && !to_file) begin
         O_ACC <= result;
      end else if (wr_acc) begin
         O_ACC <= I_PWDATA[7:0];
      end
   end

   // status flags
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_FLAGS <= `SNS_RST_FLAGS;
      end else if (take && is_sub) begin
         O_FLAGS.c                 <= diff9[8];
         O_FLAGS.nibble_borrow_bit <= nib5[4];
         O_FLAGS.z                 <= (diff9[7:0] == 8'h00);
      end else if (wr_status) begin
         O_FLAGS.c                 <= I_PWDATA[`SNS_BIT_C];
         O_FLAGS.nibble_borrow_bit <= I_PWDATA[`SNS_BIT_DC];
         O_FLAGS.z                 <= I_PWDATA[`SNS_BIT_Z];
      end
   end

   // register file write port
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_FILE_WR <= '0;
      end else begin
         O_FILE_WR.we <= take && op != sns_pkg::SNS_OP_NONE && to_file;
         if (take && op != sns_pkg::SNS_OP_NONE && to_file) begin
            O_FILE_WR.addr <= I_INSTR[6:0];
            O_FILE_WR.data <= result;
         end
      end
   end

   // completion pulses and last result
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_DONE      <= 1'b0;
         O_UNKNOWN   <= 1'b0;
         last_result <= `SNS_RST_RESULT;
      end else begin
         O_DONE    <= take && op != sns_pkg::SNS_OP_NONE;
         O_UNKNOWN <= take && op == sns_pkg::SNS_OP_NONE;
         if (take && op != sns_pkg::SNS_OP_NONE) begin
            last_result <= result;
         end
      end
   end

   // control register
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         enable <= `SNS_RST_EN;
      end else if (wr_ctrl) begin
         enable <= I_PWDATA[`SNS_BIT_EN];
      end
   end

   // read data is captured in the setup cycle
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_PRDATA <= 32'h0000_0000;
         bad_addr <= 1'b0;
      end else if (I_PSEL && !I_PENABLE) begin
         bad_addr <= 1'b0;
         case (I_PADDR)
            ADDR_W'(`SNS_OFF_ACC):    O_PRDATA <= {24'h00_0000, O_ACC};
            ADDR_W'(`SNS_OFF_STATUS): O_PRDATA <= {29'h0000_0000, O_FLAGS};
            ADDR_W'(`SNS_OFF_CTRL):   O_PRDATA <= {31'h0000_0000, enable};
            ADDR_W'(`SNS_OFF_RESULT): O_PRDATA <= {24'h00_0000, last_result};
            default: begin
               O_PRDATA <= 32'h0000_0000;
               bad_addr <= 1'b1;
            end
         endcase
      end
   end

   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = I_PSEL & I_PENABLE & bad_addr;

   // checks
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RST);

   a_lit_sub_acc: assert property (
      take && op == sns_pkg::SNS_OP_LIT_MINUS_ACC
      |=> O_ACC == 8'($past(I_INSTR[7:0]) - $past(O_ACC)) && !O_FILE_WR.we)
      else $error("literal subtract result wrong");

   a_reg_sub_value: assert property (
      take && op == sns_pkg::SNS_OP_REG_MINUS_ACC && to_file
      |=> O_FILE_WR.we && O_FILE_WR.data == 8'($past(I_FILE_RDATA) - $past(O_ACC)))
      else $error("register subtract result wrong");

   a_sub_dest_acc: assert property (
      take && op == sns_pkg::SNS_OP_REG_MINUS_ACC && !to_file
      |=> !O_FILE_WR.we && O_ACC == 8'($past(I_FILE_RDATA) - $past(O_ACC)))
      else $error("subtract to accumulator wrong");

   a_sub_dest_file: assert property (
      take && is_sub && to_file && !wr_acc
      |=> $stable(O_ACC) && O_FILE_WR.addr == $past(I_INSTR[6:0]))
      else $error("subtract to register disturbed accumulator");

   a_carry_borrow: assert property (
      take && is_sub |=> O_FLAGS.c == ($past(operand) >= $past(O_ACC)))
      else $error("carry not inverted borrow");

   a_swap_nibbles: assert property (
      take && op == sns_pkg::SNS_OP_NIBBLE_EXCHANGE
      |=> (O_FILE_WR.we ? O_FILE_WR.data : O_ACC)
          == {$past(I_FILE_RDATA[3:0]), $past(I_FILE_RDATA[7:4])})
      else $error("nibble exchange wrong");

   a_swap_flags_keep: assert property (
      take && op == sns_pkg::SNS_OP_NIBBLE_EXCHANGE && !wr_status
      |=> $stable(O_FLAGS) && O_FILE_WR.we == $past(to_file))
      else $error("nibble exchange touched flags");

   a_zero_flag: assert property (
      take && is_sub |=> O_FLAGS.z == ($past(operand) == $past(O_ACC)))
      else $error("zero flag wrong");

   a_digit_flag: assert property (
      take && is_sub
      |=> O_FLAGS.nibble_borrow_bit == ($past(operand[3:0]) >= $past(O_ACC[3:0])))
      else $error("nibble borrow bit wrong");

   c_lit_sub: cover property (take && op == sns_pkg::SNS_OP_LIT_MINUS_ACC);
   c_reg_sub_file: cover property (take && op == sns_pkg::SNS_OP_REG_MINUS_ACC && to_file);
   c_swap_acc: cover property (take && op == sns_pkg::SNS_OP_NIBBLE_EXCHANGE && !to_file);
   c_negative: cover property (take && is_sub && !diff9[8]);

endmodule : sns_ops

// *** verification/test_subtract_and_nibble_swap_ops.sv ***
// self-checking bench for the subtract and nibble exchange datapath
`timescale 1ns/1ps
`include "sns_defines.svh"
module test_subtract_and_nibble_swap_ops;
   logic                   clk, rst, exec, psel, penable, pwrite, pready, pslverr, done, unknown;
   logic                   m_en, err;
   logic [13:0]            instr;
   logic [7:0]             rdata, acc, m_acc, m_res;
   logic [11:0]            paddr;
   logic [31:0]            pwdata, prdata, rd, t;
   sns_pkg::sns_fwr_type   fwr;
   sns_pkg::sns_flags_type flags, m_flags;
   logic [27:0]            notes[$];
   logic [27:0]            obs, exp;
   logic [31:0]            tbl[7] = '{32'h0100_0200, 32'h0200_0200, 32'h0300_0200,
                                      32'h0201_8503, 32'h0201_8502, 32'h0201_8501, 32'h0002_05A5};
   int                     errors, total_checks, seed;

   sns_ops dut (.I_CORE_CLK(clk), .I_RST(rst), .I_EXEC(exec), .I_INSTR(instr),
      .I_FILE_RDATA(rdata), .O_FILE_WR(fwr), .O_ACC(acc), .O_FLAGS(flags), .O_DONE(done),
      .O_UNKNOWN(unknown), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata),
      .O_PSLVERR(pslverr));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic compare(input logic [31:0] got, input logic [31:0] want);
      total_checks++;
      if (got !== want) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask : compare

   task automatic compare_note(input logic [27:0] got, input logic [27:0] want);
      total_checks++;
      if (got !== want) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask : compare_note

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   // one instruction; kind 0 literal, 1 reg minus acc, 2 exchange, 3 unhandled
   task automatic run(input logic [1:0] kind, input logic [7:0] lo, input logic [7:0] r);
      logic [13:0] w;
      logic [7:0]  opnd, res;
      logic        d;
      w = (kind == 2'd0) ? {5'b11110, r[0], lo} : (kind == 2'd1) ? {6'b000010, lo} :
          (kind == 2'd2) ? {6'b001110, lo} : {6'b111010, lo};
      opnd = (kind == 2'd0) ? lo : r;
      res = (kind == 2'd2) ? {r[3:0], r[7:4]} : opnd - m_acc;
      d = (kind == 2'd1 || kind == 2'd2) && lo[7];
      // a disabled block takes nothing, so the model stands still too
      if (m_en && kind < 2'd2)
         m_flags = '{z: res == 8'h00, nibble_borrow_bit: opnd[3:0] >= m_acc[3:0],
                     c: opnd >= m_acc};
      if (m_en && kind != 2'd3 && !d)
         m_acc = res;
      if (m_en && kind != 2'd3)
         m_res = res;
      if (m_en)
         notes.push_back({kind == 2'd3, m_acc, m_flags, d, d ? lo[6:0] : 7'h00, d ? res : 8'h00});
      @(posedge clk);
      exec <= 1'b1;
      instr <= w;
      rdata <= r;
   endtask : run

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk);
      exec <= 1'b0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // wait for pready at a rising edge; a hang is ended by the watchdog
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic check_reg(input logic [11:0] a, input logic [31:0] want, input logic we);
      apb(1'b0, a, 32'h0000_0000);
      compare(rd, want);
      compare({31'h0, err}, {31'h0, we});
   endtask : check_reg

   // result monitor: every pulse takes the oldest note
   initial forever begin
      @(negedge clk);
      if (done === 1'b1 || unknown === 1'b1) begin
         obs = {unknown, acc, flags, fwr.we, fwr.we ? fwr.addr : 7'h00, fwr.we ? fwr.data : 8'h00};
         exp = (notes.size() > 0) ? notes.pop_front() : 28'hxxx_xxxx;
         compare_note(obs, exp);
      end
   end

   initial begin
      #200000;
      errors++;
      tally_and_finish();
   end

   initial begin
      {rst, exec, psel, penable, pwrite, m_en} = 6'b100001;
      {instr, rdata, paddr, pwdata, m_acc, m_res, m_flags} = '0;
      {errors, total_checks, seed} = {32'd0, 32'd0, 32'd89};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      check_reg(`SNS_OFF_ACC, 32'h0000_0000, 1'b0);
      check_reg(`SNS_OFF_STATUS, 32'h0000_0000, 1'b0);
      check_reg(`SNS_OFF_CTRL, 32'h0000_0001, 1'b0);
      check_reg(`SNS_OFF_RESULT, 32'h0000_0000, 1'b0);
      $display("reset values done");
      foreach (tbl[i]) begin
         t = tbl[i];
         apb(1'b1, `SNS_OFF_ACC, {24'h0, t[31:24]});
         m_acc = t[31:24];
         run(t[17:16], t[15:8], t[7:0]);
      end
      $display("directed examples done");
      repeat (80) begin
         t = $random(seed);
         run(t[1:0], t[15:8], t[23:16]);
      end
      check_reg(`SNS_OFF_ACC, {24'h0, m_acc}, 1'b0);
      check_reg(`SNS_OFF_STATUS, {29'h0, m_flags}, 1'b0);
      check_reg(`SNS_OFF_RESULT, {24'h0, m_res}, 1'b0);
      $display("random back to back done");
      apb(1'b1, `SNS_OFF_STATUS, 32'h0000_0005);
      m_flags = 3'h5;
      check_reg(`SNS_OFF_STATUS, 32'h0000_0005, 1'b0);
      apb(1'b1, `SNS_OFF_RESULT, 32'h0000_00FF);
      check_reg(`SNS_OFF_RESULT, {24'h0, m_res}, 1'b0);
      run(2'd2, 8'h00, 8'hC3);
      check_reg(`SNS_OFF_STATUS, 32'h0000_0005, 1'b0);
      $display("status and result registers done");
      apb(1'b1, `SNS_OFF_CTRL, 32'h0000_0000);
      m_en = 1'b0;
      run(2'd0, 8'h77, 8'h00);
      check_reg(`SNS_OFF_ACC, {24'h0, m_acc}, 1'b0);
      apb(1'b1, `SNS_OFF_CTRL, 32'h0000_0001);
      m_en = 1'b1;
      check_reg(12'h010, 32'h0000_0000, 1'b1);
      repeat (3) @(posedge clk);
      compare(notes.size(), 32'd0);
      $display("disable and unmapped done");
      tally_and_finish();
   end
endmodule : test_subtract_and_nibble_swap_ops
